/* design/questionable_status_event_condition.sv */
/*
  Per-channel questionable status: live condition register, transition
  filters and latched event register, read by channel-list queries.
  Assumes status inputs and command strobes are synchronous to clk and
  that the answer port accepts one answer per cycle.
*/
`timescale 1ns/1ns
module questionable_status_event_condition #(
  parameter int NUM_CH = qstat_pkg::NUM_CH_DEFAULT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire qstat_pkg::status_bits_t [NUM_CH-1:0] status_in,
  input wire logic query_valid,
  input wire qstat_pkg::query_t query,
  input wire logic filt_wr_valid,
  input wire qstat_pkg::filt_wr_t filt_wr,
  input wire logic clear_status,
  input wire logic status_preset,
  output logic query_ready,
  output logic resp_valid,
  output qstat_pkg::resp_t resp
);

  // Scan states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SCAN = 1'b1
  } scan_state_t;

  // One bit per instantiated channel; higher list bits are dropped
  localparam logic [qstat_pkg::MAX_CH-1:0] CH_PRESENT =
    {qstat_pkg::MAX_CH{1'b1}} >> (qstat_pkg::MAX_CH - NUM_CH);

  // Per-channel storage
  logic [qstat_pkg::DEF_W-1:0] cond_reg [NUM_CH]; // Last sample of inputs
  logic [qstat_pkg::DEF_W-1:0] cond_next [NUM_CH];
  logic [qstat_pkg::DEF_W-1:0] event_reg [NUM_CH]; // Latched events
  logic [qstat_pkg::DEF_W-1:0] event_next [NUM_CH];
  logic [qstat_pkg::DEF_W-1:0] rise_filt_reg [NUM_CH]; // Rising filter
  logic [qstat_pkg::DEF_W-1:0] rise_filt_next [NUM_CH];
  logic [qstat_pkg::DEF_W-1:0] fall_filt_reg [NUM_CH]; // Falling filter
  logic [qstat_pkg::DEF_W-1:0] fall_filt_next [NUM_CH];
  logic [qstat_pkg::DEF_W-1:0] set_bits [NUM_CH]; // Events passed this cycle
  logic [NUM_CH-1:0] read_clr; // Clearing read per channel

  // Query scanner
  scan_state_t state_reg, state_next;
  qstat_pkg::reg_sel_t sel_reg, sel_next; // Register being read
  logic [qstat_pkg::MAX_CH-1:0] mask_reg, mask_next; // Channels still owed
  logic [qstat_pkg::CH_IDX_W-1:0] idx_reg, idx_next; // Channel looked at
  logic ready_reg, ready_next;
  logic resp_valid_reg, resp_valid_next;
  qstat_pkg::resp_t resp_reg, resp_next;
  logic answering; // Current channel is owed an answer
  logic [qstat_pkg::MAX_CH-1:0] mask_left; // Owed after this cycle
  logic [qstat_pkg::DEF_W-1:0] read_word; // Selected register contents

  // Filter and edge logic for every channel
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      // Inputs land in the condition register every edge
      cond_next[ch] = status_in[ch] & qstat_pkg::DEFINED_MASK;
      // Edges compare new input with the previous sample
      set_bits[ch] = (status_in[ch] & ~cond_reg[ch] & rise_filt_reg[ch])
                   | (~status_in[ch] & cond_reg[ch] & fall_filt_reg[ch]);
      // Clear first, then OR in new events so a collision keeps them
      event_next[ch] = (read_clr[ch] || clear_status) ? qstat_pkg::EVENT_RESET
                                                        : event_reg[ch];
      event_next[ch] = event_next[ch] | set_bits[ch];
      // Filters are the only writable state; events have no write path
      rise_filt_next[ch] = rise_filt_reg[ch];
      fall_filt_next[ch] = fall_filt_reg[ch];
      if (status_preset) begin
        // Preset wins over a write in the same cycle
        rise_filt_next[ch] = qstat_pkg::RISE_FILT_PRESET;
        fall_filt_next[ch] = qstat_pkg::FALL_FILT_PRESET;
      end else if (filt_wr_valid && filt_wr.chans[ch]) begin
        if (filt_wr.sel == qstat_pkg::FILT_RISING) begin
          rise_filt_next[ch] = filt_wr.value[qstat_pkg::DEF_W-1:0];
        end else begin
          fall_filt_next[ch] = filt_wr.value[qstat_pkg::DEF_W-1:0];
        end
      end
    end
  end

  // Channel registers; filters start at their preset values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        cond_reg[ch] <= qstat_pkg::COND_RESET;
        event_reg[ch] <= qstat_pkg::EVENT_RESET;
        rise_filt_reg[ch] <= qstat_pkg::RISE_FILT_PRESET;
        fall_filt_reg[ch] <= qstat_pkg::FALL_FILT_PRESET;
      end
    end else begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        cond_reg[ch] <= cond_next[ch];
        event_reg[ch] <= event_next[ch];
        rise_filt_reg[ch] <= rise_filt_next[ch];
        fall_filt_reg[ch] <= fall_filt_next[ch];
      end
    end
  end

  // Clearing read strobes, only for event queries
  always_comb begin
    for (int ch = 0; ch < NUM_CH; ch++) begin
      read_clr[ch] = answering && (sel_reg == qstat_pkg::REG_EVENT)
                   && (idx_reg == ch[qstat_pkg::CH_IDX_W-1:0]);
    end
  end

  // Register selected by the scan position
  always_comb begin
    read_word = qstat_pkg::EVENT_RESET;
    for (int ch = 0; ch < NUM_CH; ch++) begin
      if (idx_reg == ch[qstat_pkg::CH_IDX_W-1:0]) begin
        read_word = (sel_reg == qstat_pkg::REG_EVENT) ? event_reg[ch] : cond_reg[ch];
      end
    end
  end

  // Scanner: one channel per cycle, one answer per named channel
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    mask_next = mask_reg;
    idx_next = idx_reg;
    resp_valid_next = 1'b0;
    resp_next = resp_reg;
    answering = (state_reg == ST_SCAN) && mask_reg[idx_reg];
    mask_left = mask_reg;
    mask_left[idx_reg] = 1'b0;
    unique case (state_reg)
      ST_IDLE: begin
        // A query with no present channel is dropped
        if (query_valid && ready_reg && ((query.chans & CH_PRESENT) != '0)) begin
          state_next = ST_SCAN;
          sel_next = query.sel;
          mask_next = query.chans & CH_PRESENT;
          idx_next = '0;
        end
      end
      ST_SCAN: begin
        if (answering) begin
          resp_valid_next = 1'b1;
          resp_next.chan = idx_reg;
          resp_next.sel = sel_reg;
          // Unused high bits always zero; value is the weighted sum
          resp_next.value = {qstat_pkg::UNUSED_BITS, read_word};
          resp_next.decimal = qstat_pkg::to_decimal({qstat_pkg::UNUSED_BITS, read_word});
          resp_next.last = (mask_left == '0);
        end
        mask_next = mask_left;
        idx_next = idx_reg + 1'b1;
        if (mask_left == '0) begin
          state_next = ST_IDLE;
        end
      end
    endcase
    // Ready is registered, so it follows the next state
    ready_next = (state_next == ST_IDLE);
  end

  // Scanner registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      sel_reg <= qstat_pkg::REG_EVENT;
      mask_reg <= '0;
      idx_reg <= '0;
      ready_reg <= 1'b0;
      resp_valid_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      state_reg <= state_next;
      sel_reg <= sel_next;
      mask_reg <= mask_next;
      idx_reg <= idx_next;
      ready_reg <= ready_next;
      resp_valid_reg <= resp_valid_next;
      resp_reg <= resp_next;
    end
  end

  assign query_ready = ready_reg;
  assign resp_valid = resp_valid_reg;
  assign resp = resp_reg;

  // Checks on channel 0 and on the answer port
  localparam int SCAN_MAX = 9;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Latched bits survive while no clear is pending
  a_event_bits_hold: assert property ((!read_clr[0] && !clear_status) |=>
      ((event_reg[0] & $past(event_reg[0])) == $past(event_reg[0])))
    else $error("event bit dropped without a clear");

  // New events land even during a clearing read
  a_event_set_wins: assert property ((set_bits[0] != '0) |=>
      ((event_reg[0] & $past(set_bits[0])) == $past(set_bits[0])))
    else $error("filtered event lost");

  // Rising input edge through an enabled rising filter
  a_rise_sets_event: assert property (
      ((status_in[0] & ~cond_reg[0] & rise_filt_reg[0]) != '0) |=>
      ((event_reg[0] & $past(status_in[0] & rise_filt_reg[0])) != '0))
    else $error("rising edge did not set event");

  // Falling input edge through an enabled falling filter
  a_fall_sets_event: assert property (
      ((~status_in[0] & cond_reg[0] & fall_filt_reg[0]) != '0) |=>
      ((event_reg[0] & $past(cond_reg[0] & fall_filt_reg[0])) != '0))
    else $error("falling edge did not set event");

  // Both filters off: an empty register stays empty
  a_filters_off_quiet: assert property ((rise_filt_reg[0] == '0 && fall_filt_reg[0] == '0
      && event_reg[0] == '0) |=> (event_reg[0] == '0))
    else $error("event set with both filters off");

  // A clearing read with no new event empties the register
  a_read_clears: assert property ((read_clr[0] && set_bits[0] == '0) |=>
      (event_reg[0] == '0))
    else $error("event read did not clear");

  // Condition reads leave the event register alone
  a_cond_read_pure: assert property ((state_reg == ST_SCAN && sel_reg == qstat_pkg::REG_CONDITION
      && !clear_status && set_bits[0] == '0) |=> (event_reg[0] == $past(event_reg[0])))
    else $error("condition read changed events");

  // Answers carry the register as it stood one cycle back
  a_event_answer_value: assert property ((resp_valid_reg && resp_reg.chan == '0) |->
      (resp_reg.value[qstat_pkg::DEF_W-1:0] == ((resp_reg.sel == qstat_pkg::REG_EVENT)
      ? $past(event_reg[0]) : $past(cond_reg[0]))))
    else $error("answer does not match register");

  // Condition follows input with one edge of delay
  a_cond_follows: assert property (##1 (cond_reg[0] == $past(status_in[0])))
    else $error("condition register not live");

  // Unused bits zero and decimal digits match value
  a_answer_format: assert property (resp_valid_reg |-> (resp_reg.value[15:13] == 3'h0
      && resp_reg.decimal == qstat_pkg::to_decimal(resp_reg.value)))
    else $error("answer format wrong");

  // Preset restores both filters next edge
  a_preset_filters: assert property (status_preset |=>
      (rise_filt_reg[0] == qstat_pkg::RISE_FILT_PRESET && fall_filt_reg[0] == '0))
    else $error("preset did not restore filters");

  // An accepted query answers within the scan length
  a_query_answered: assert property ((query_valid && ready_reg
      && ((query.chans & CH_PRESENT) != '0)) |-> ##[2:SCAN_MAX] (resp_valid_reg && resp_reg.last))
    else $error("query not completed in time");

  // Clear-status empties the register when nothing new arrives
  a_clear_empties: assert property ((clear_status && set_bits[0] == '0) |=>
      (event_reg[0] == '0))
    else $error("clear-status left event bits");

  // Filter writes never reach the event register
  a_event_read_only: assert property ((filt_wr_valid && set_bits[0] == '0 && !read_clr[0]
      && !clear_status) |=> (event_reg[0] == $past(event_reg[0])))
    else $error("filter write changed events");

  // Channel 0 inputs by field, for the bit position checks
  qstat_pkg::status_bits_t in0;
  assign in0 = status_in[0];

  // Bits 0 to 5 sit at their weights
  a_bit_map_low: assert property (##1 (
      cond_reg[0][qstat_pkg::BIT_OVERVOLTAGE_TRIP] == $past(in0.overvoltage_trip)
      && cond_reg[0][qstat_pkg::BIT_OVERCURRENT_TRIP] == $past(in0.overcurrent_trip)
      && cond_reg[0][qstat_pkg::BIT_POWER_FAIL] == $past(in0.power_fail)
      && cond_reg[0][qstat_pkg::BIT_POS_POWER_LIMIT] == $past(in0.positive_power_limit)
      && cond_reg[0][qstat_pkg::BIT_OVERTEMP_TRIP] == $past(in0.overtemp_trip)
      && cond_reg[0][qstat_pkg::BIT_NEG_POWER_LIMIT] == $past(in0.negative_power_limit)))
    else $error("low status bit misplaced");

  // Bits 6 to 12 sit at their weights
  a_bit_map_high: assert property (##1 (
      cond_reg[0][qstat_pkg::BIT_NEG_OVERVOLTAGE] == $past(in0.negative_overvoltage_trip)
      && cond_reg[0][qstat_pkg::BIT_POS_VI_LIMIT] == $past(in0.positive_vi_limit)
      && cond_reg[0][qstat_pkg::BIT_NEG_VI_LIMIT] == $past(in0.negative_vi_limit)
      && cond_reg[0][qstat_pkg::BIT_EXTERNAL_INHIBIT] == $past(in0.external_inhibit)
      && cond_reg[0][qstat_pkg::BIT_UNREGULATED] == $past(in0.unregulated_output)
      && cond_reg[0][qstat_pkg::BIT_COUPLED_PROTECTION] == $past(in0.coupled_protection)
      && cond_reg[0][qstat_pkg::BIT_OSCILLATION_TRIP] == $past(in0.oscillation_trip)))
    else $error("high status bit misplaced");

  // Answers come only out of a scan cycle
  a_answer_from_scan: assert property (resp_valid_reg |-> $past(state_reg == ST_SCAN))
    else $error("answer outside a scan");

  // A query naming no present channel leaves the scanner idle
  a_refused_query: assert property ((state_reg == ST_IDLE && query_valid && ready_reg
      && ((query.chans & CH_PRESENT) == '0)) |=> (state_reg == ST_IDLE && ready_reg))
    else $error("refused query started a scan");

  // The last answer and ready arrive on the same edge
  a_last_frees_ready: assert property ((resp_valid_reg && resp_reg.last) |-> ready_reg)
    else $error("ready late after last answer");

  // Main scenarios
  c_event_read: cover property (resp_valid_reg && resp_reg.sel == qstat_pkg::REG_EVENT
      && resp_reg.value != '0);
  c_cond_read: cover property (resp_valid_reg && resp_reg.sel == qstat_pkg::REG_CONDITION);
  c_multi_channel: cover property (resp_valid_reg && !resp_reg.last ##1 resp_valid_reg);
  c_read_collision: cover property (read_clr[0] && set_bits[0] != '0);
  c_clear_collision: cover property (clear_status && set_bits[0] != '0);

endmodule

/* pkg/qstat_pkg.sv */
/*
  Shared constants, types and the decimal conversion for the per-channel
  questionable status event and condition registers.
  Assumes one system clock and that status inputs are already synchronous to it.
*/
// How it works
// - Filtered condition transitions set latched event bits
// - Event register has no write path
// - Event read returns contents, then clears register
// - Event bits hold until read or clear-status
// - Condition register mirrors status inputs, unlatched
// - Condition reads leave everything unchanged
// - Bits 0-2: overvoltage, overcurrent, power fail
// - Bits 3-5: power limits, overtemperature
// - Bits 6-8: negative overvoltage, V/I limits
// - Bits 9-11: inhibit, unregulated, coupled protection
// - Bit 12 oscillation; bits 13-15 read zero
// - Answer is binary-weighted sum, decimal digits
// - Rising filter bit: 0-to-1 sets event
// - Falling filter bit: 1-to-0 sets event
// - Preset: rising filter all ones, falling zero
package qstat_pkg;

  localparam int REG_W = 16; // Width of a register as software sees it
  localparam int DEF_W = 13; // Defined bits, 0 through 12
  localparam int MAX_CH = 8; // Widest channel list a query can carry
  localparam int CH_IDX_W = 3; // Index width for MAX_CH channels
  localparam int DEC_W = 20; // Five decimal digits cover 65535
  localparam int NUM_CH_DEFAULT = 4; // Plain default channel count

  // Field positions inside a register
  localparam int BIT_OVERVOLTAGE_TRIP = 0;
  localparam int BIT_OVERCURRENT_TRIP = 1;
  localparam int BIT_POWER_FAIL = 2;
  localparam int BIT_POS_POWER_LIMIT = 3;
  localparam int BIT_OVERTEMP_TRIP = 4;
  localparam int BIT_NEG_POWER_LIMIT = 5;
  localparam int BIT_NEG_OVERVOLTAGE = 6;
  localparam int BIT_POS_VI_LIMIT = 7;
  localparam int BIT_NEG_VI_LIMIT = 8;
  localparam int BIT_EXTERNAL_INHIBIT = 9;
  localparam int BIT_UNREGULATED = 10;
  localparam int BIT_COUPLED_PROTECTION = 11;
  localparam int BIT_OSCILLATION_TRIP = 12;

  // Reset and preset values of the filters and latches
  localparam logic [DEF_W-1:0] DEFINED_MASK = 13'h1fff;
  localparam logic [DEF_W-1:0] RISE_FILT_PRESET = 13'h1fff;
  localparam logic [DEF_W-1:0] FALL_FILT_PRESET = 13'h0000;
  localparam logic [DEF_W-1:0] EVENT_RESET = 13'h0000;
  localparam logic [DEF_W-1:0] COND_RESET = 13'h0000;
  localparam logic [REG_W-DEF_W-1:0] UNUSED_BITS = 3'h0;

  // Which register a query reads
  typedef enum logic [0:0] {
    REG_EVENT = 1'b0,
    REG_CONDITION = 1'b1
  } reg_sel_t;

  // Which transition filter a write targets
  typedef enum logic [0:0] {
    FILT_RISING = 1'b0,
    FILT_FALLING = 1'b1
  } filt_sel_t;

  // Status inputs of one channel, bit 12 first
  typedef struct packed {
    logic oscillation_trip;
    logic coupled_protection;
    logic unregulated_output;
    logic external_inhibit;
    logic negative_vi_limit;
    logic positive_vi_limit;
    logic negative_overvoltage_trip;
    logic negative_power_limit;
    logic overtemp_trip;
    logic positive_power_limit;
    logic power_fail;
    logic overcurrent_trip;
    logic overvoltage_trip;
  } status_bits_t;

  // One status query: register and list of channels
  typedef struct packed {
    reg_sel_t sel;
    logic [MAX_CH-1:0] chans;
  } query_t;

  // One filter write, to one or more channels
  typedef struct packed {
    filt_sel_t sel;
    logic [MAX_CH-1:0] chans;
    logic [REG_W-1:0] value;
  } filt_wr_t;

  // One answer, one per named channel
  typedef struct packed {
    logic [CH_IDX_W-1:0] chan;
    reg_sel_t sel;
    logic [REG_W-1:0] value;
    logic [DEC_W-1:0] decimal;
    logic last;
  } resp_t;

  // Binary to five BCD digits by shift and add three
  function automatic logic [DEC_W-1:0] to_decimal(input logic [REG_W-1:0] bin);
    logic [DEC_W+REG_W-1:0] sh;
    sh = {20'h0_0000, bin};
    for (int i = 0; i < REG_W; i++) begin
      for (int d = 0; d < DEC_W / 4; d++) begin
        if (sh[REG_W+4*d +: 4] >= 4'h5) begin
          sh[REG_W+4*d +: 4] = sh[REG_W+4*d +: 4] + 4'h3;
        end
      end
      sh = {sh[DEC_W+REG_W-2:0], 1'b0};
    end
    return sh[DEC_W+REG_W-1:REG_W];
  endfunction

endpackage

/* sim/questionable_status_event_condition_tb.sv */
/*
  Self-checking bench for the questionable status block.
  Assumes the host model in status_host.sv; four channels instantiated.
*/
`timescale 1ns/1ns
module questionable_status_event_condition_tb;
  localparam int NCH = 4; // Channels instantiated
  logic clk, rstn, query_valid, query_ready, resp_valid;
  logic filt_wr_valid, clear_status, status_preset;
  qstat_pkg::status_bits_t [NCH-1:0] status_in; // Live inputs
  qstat_pkg::query_t query;
  qstat_pkg::filt_wr_t filt_wr;
  qstat_pkg::resp_t resp;
  logic [12:0] ev [NCH]; // Expected latched events
  logic [12:0] rise, fall; // Expected filters, same on all channels
  int failures, checks;

  questionable_status_event_condition #(.NUM_CH(NCH)) u_dut (.clk(clk), .rstn(rstn),
    .status_in(status_in), .query_valid(query_valid), .query(query),
    .filt_wr_valid(filt_wr_valid), .filt_wr(filt_wr), .clear_status(clear_status),
    .status_preset(status_preset), .query_ready(query_ready),
    .resp_valid(resp_valid), .resp(resp));
  status_host u_host (.clk(clk), .query_ready(query_ready), .resp_valid(resp_valid),
    .resp(resp), .query_valid(query_valid), .query(query));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Single comparison point
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Decimal digits by division, independent of the design
  function automatic logic [19:0] bcd(input logic [15:0] v);
    logic [19:0] r;
    for (int i = 0; i < 5; i++) r[4*i +: 4] = 4'((v / (10 ** i)) % 10);
    return r;
  endfunction

  // New level on one channel; model the filtered transitions
  task automatic set_st(input int ch, input logic [12:0] v);
    logic [12:0] old;
    @(negedge clk);
    old = status_in[ch];
    ev[ch] = ev[ch] | (~old & v & rise) | (old & ~v & fall);
    status_in[ch] = v;
  endtask

  // Filter write to every channel
  task automatic wr_filt(input qstat_pkg::filt_sel_t sel, input logic [12:0] v);
    @(negedge clk);
    filt_wr_valid = 1'b1;
    filt_wr.sel = sel;
    filt_wr.chans = 8'hff;
    filt_wr.value = {3'h7, v}; // Top bits must be ignored
    @(negedge clk);
    filt_wr_valid = 1'b0;
    filt_wr = ~filt_wr;
    if (sel == qstat_pkg::FILT_RISING) rise = v;
    else fall = v;
  endtask

  // Clear-status (pre=0) or preset (pre=1) pulse
  task automatic cmd(input bit pre);
    @(negedge clk);
    status_preset = pre;
    clear_status = !pre;
    @(negedge clk);
    status_preset = 1'b0;
    clear_status = 1'b0;
    if (pre) {rise, fall} = {13'h1fff, 13'h0000};
    else for (int i = 0; i < NCH; i++) ev[i] = 13'h0000;
  endtask

  // Query and compare every channel, named or not
  task automatic q(input qstat_pkg::reg_sel_t sel, input logic [7:0] chans);
    logic [15:0] e;
    u_host.ask(sel, chans);
    for (int ch = 0; ch < NCH; ch++) begin
      e = (sel == qstat_pkg::REG_CONDITION) ? {3'h0, status_in[ch]} : {3'h0, ev[ch]};
      check(20'(u_host.seen[ch]), 20'(chans[ch]));
      if (chans[ch]) begin
        check(20'(u_host.got[ch]), 20'(e));
        check(u_host.got_dec[ch], bcd(e));
        if (sel == qstat_pkg::REG_EVENT) ev[ch] = 13'h0000;
      end
    end
  endtask

  task automatic stop_test();
    $display("Counts: %0d checks, %0d failures", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Hang guard, 10,000 cycles, several times the expected run
  initial begin
    #200_000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  // Main sequence
  initial begin
    {rstn, filt_wr_valid, clear_status, status_preset} = 4'h0;
    filt_wr = '0;
    status_in = '0;
    {rise, fall} = {13'h1fff, 13'h0000};
    failures = 0;
    checks = 0;
    for (int i = 0; i < NCH; i++) ev[i] = 13'h0000;
    void'($urandom(32'hdddb));
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    q(qstat_pkg::REG_CONDITION, 8'h0f);
    q(qstat_pkg::REG_EVENT, 8'h0f);
    q(qstat_pkg::REG_EVENT, 8'h00);
    check(20'(query_ready), 20'h0_0001);
    $display("Test reset and empty list done");
    // Each defined bit alone, on rotating channels
    for (int b = 0; b < 13; b++) begin
      set_st(b % NCH, 13'(1 << b));
      repeat (2) q(qstat_pkg::REG_CONDITION, 8'(1 << (b % NCH)));
      set_st(b % NCH, 13'h0000);
      q(qstat_pkg::REG_EVENT, 8'(1 << (b % NCH)));
      q(qstat_pkg::REG_EVENT, 8'(1 << (b % NCH)));
    end
    $display("Test bit walk done");
    wr_filt(qstat_pkg::FILT_RISING, 13'h0000);
    wr_filt(qstat_pkg::FILT_FALLING, 13'h1fff);
    set_st(1, 13'h0a5a);
    set_st(1, 13'h0000);
    set_st(2, 13'h1fff);
    set_st(2, 13'h0000);
    wr_filt(qstat_pkg::FILT_FALLING, 13'h0000);
    q(qstat_pkg::REG_EVENT, 8'h02);
    cmd(1'b0);
    q(qstat_pkg::REG_EVENT, 8'h04);
    set_st(3, 13'h1fff);
    set_st(3, 13'h0000);
    q(qstat_pkg::REG_EVENT, 8'h08);
    cmd(1'b1);
    set_st(3, 13'h1fff);
    set_st(3, 13'h0000);
    q(qstat_pkg::REG_EVENT, 8'h08);
    $display("Test filters, clear and preset done");
    // Event with clear-status, then one during the clearing read of channel 0
    @(negedge clk);
    clear_status = 1'b1;
    status_in[0] = 13'h0011;
    @(negedge clk);
    clear_status = 1'b0;
    for (int i = 0; i < NCH; i++) ev[i] = 13'h0000;
    fork
      u_host.ask(qstat_pkg::REG_EVENT, 8'h01);
      begin
        repeat (2) @(negedge clk);
        status_in[0] = 13'h0111;
      end
    join
    check(20'(u_host.seen[0]), 20'h0_0001);
    check(20'(u_host.got[0]), 20'h0_0011);
    ev[0] = 13'h0100;
    q(qstat_pkg::REG_EVENT, 8'h0f);
    $display("Test set against clear done");
    // Random levels, filters and channel lists
    for (int i = 0; i < 60; i++) begin
      set_st(int'($urandom % NCH), 13'($urandom));
      if (i % 10 == 5) wr_filt(qstat_pkg::filt_sel_t'($urandom % 2), 13'($urandom));
      if (i % 3 == 0) q(qstat_pkg::reg_sel_t'($urandom % 2), 8'($urandom));
    end
    $display("Test random traffic done");
    stop_test();
  end
endmodule

/* sim/status_host.sv */
/*
  Host model that issues status queries and gathers the answers.
  Assumes registered ready and answer outputs on the rising clock edge.
*/
`timescale 1ns/1ns
module status_host (
  input wire logic clk,
  input wire logic query_ready,
  input wire logic resp_valid,
  input wire qstat_pkg::resp_t resp,
  output logic query_valid,
  output qstat_pkg::query_t query
);
  logic [15:0] got [8]; // Value answered per channel
  logic [19:0] got_dec [8]; // Decimal digits per channel
  logic [7:0] seen; // Channels that answered

  // Idle at time zero
  initial begin
    query_valid = 1'b0;
    query = '0;
  end

  // One query, held until an edge finds ready high
  task automatic ask(input qstat_pkg::reg_sel_t sel, input logic [7:0] chans);
    int n;
    seen = 8'h00;
    @(negedge clk);
    query_valid = 1'b1;
    query.sel = sel;
    query.chans = chans;
    n = 0;
    // Ready looked at where it is settled; the next rising edge takes it
    while (query_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    query_valid = 1'b0;
    // Released: fields no longer show the old query
    query = ~query;
    // Answers stand one cycle, so look at each negedge
    for (n = 0; n < 12; n++) begin
      if (resp_valid === 1'b1) begin
        seen[resp.chan] = 1'b1;
        got[resp.chan] = resp.value;
        got_dec[resp.chan] = resp.decimal;
        if (resp.last === 1'b1) break;
      end
      @(negedge clk);
    end
  endtask
endmodule
